// [hw/bac_defs.svh]
// constants for the bus address and sync configuration block
`ifndef BAC_DEFS_SVH
`define BAC_DEFS_SVH

// ----------------------------------------------------------------
// address range and factory values
// ----------------------------------------------------------------
`define BAC_ADDR_W        7
`define BAC_ADDR_MIN      7'h01
`define BAC_ADDR_MAX      7'h7E
`define BAC_ADDR_CH1_RST  7'h7E
`define BAC_ADDR_CH2_RST  7'h7D
`define BAC_ADDR_STEP     7'h01

// ----------------------------------------------------------------
// switch fields
// ----------------------------------------------------------------
`define BAC_ASW_W         6
`define BAC_SYNC_S1       0
`define BAC_SYNC_S2       1

// ----------------------------------------------------------------
// sync and timing
// ----------------------------------------------------------------
`define BAC_FREQ_W        16
`define BAC_SYNC_MIN_HZ   16'h0032
`define BAC_EXC_W         3
`define BAC_CLK_HZ        10000000
`define BAC_SETTLE_US     1000
`define BAC_SETTLE_CYC    (`BAC_SETTLE_US * (`BAC_CLK_HZ / 1000000))

`endif

// [hw/bac_pkg.sv]
// types shared by the bus address and sync configuration block
package bac_pkg;

	// ----------------------------------------------------------------
	// switch-selected sync modes, code is {s1, s2}
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BAC_SYNC_INDEP = 2'b00,  // both independent
		BAC_SYNC_M_S   = 2'b01,  // ch1 master, ch2 slave
		BAC_SYNC_S_I   = 2'b10,  // ch1 slave, ch2 independent
		BAC_SYNC_S_S   = 2'b11   // both slave
	} bac_sync_e;

	// per channel role
	typedef enum logic [1:0] {
		BAC_ROLE_INDEP  = 2'b00,
		BAC_ROLE_MASTER = 2'b01,
		BAC_ROLE_SLAVE  = 2'b10
	} bac_role_e;

	// power-up sequence
	typedef enum logic [0:0] {
		BAC_ST_SETTLE = 1'b0,  // waiting for switches to settle
		BAC_ST_RUN    = 1'b1   // settings frozen
	} bac_state_e;

	typedef logic [6:0] bac_addr_t;

	// role of one channel for a given switch mode
	function automatic bac_role_e bac_chan_role(input bac_sync_e mode, input logic is_ch2);
		unique case (mode)
			BAC_SYNC_INDEP: bac_chan_role = BAC_ROLE_INDEP;
			BAC_SYNC_M_S:   bac_chan_role = is_ch2 ? BAC_ROLE_SLAVE : BAC_ROLE_MASTER;
			BAC_SYNC_S_I:   bac_chan_role = is_ch2 ? BAC_ROLE_INDEP : BAC_ROLE_SLAVE;
			BAC_SYNC_S_S:   bac_chan_role = BAC_ROLE_SLAVE;
		endcase
	endfunction

endpackage

// [hw/bac_addr_fix.sv]
// range check and parity correction of one software-written address
`include "bac_defs.svh"

module bac_addr_fix
	import bac_pkg::*;
(
	input  wire bac_addr_t wr_val,     // value written by software
	input  wire logic      is_ch2,     // target is channel 2
	input  wire logic      two_chan,   // unit has two channels
	output bac_addr_t      fixed_val,  // value to store
	output logic           in_range,   // value lies in the legal window
	output logic           corrected   // parity was wrong and got moved
);

	// ----------------------------------------------------------------
	// range and parity
	// ----------------------------------------------------------------
	// out-of-range values are refused, never clamped
	assign in_range = (wr_val >= `BAC_ADDR_MIN) && (wr_val <= `BAC_ADDR_MAX);

	// ch1 wants even, ch2 wants odd; single-channel units take any value
	assign corrected = two_chan && (is_ch2 ? !wr_val[0] : wr_val[0]);

	// ch1 moves up, ch2 moves down; in-range values stay inside 1..126 by construction
	assign fixed_val = !corrected ? wr_val :
		(is_ch2 ? bac_addr_t'(wr_val - `BAC_ADDR_STEP) : bac_addr_t'(wr_val + `BAC_ADDR_STEP));

endmodule

// [hw/bac_config.sv]
// bus address and sync mode configuration for a one- or two-channel sensor controller
`include "bac_defs.svh"

module bac_config
	import bac_pkg::*;
#(
	parameter int SETTLE_CYCLES = `BAC_SETTLE_CYC  // settle wait before switches are sampled
)(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic [`BAC_ASW_W-1:0]    addr_sw,          // address switches, bit 0 is s1
	input  wire logic [1:0]               sync_sw,          // sync switches s1, s2
	input  wire logic                     two_chan_strap,   // unit fitted with two channels
	input  wire logic                     sw_addr_strap,    // addresses come from switches when two_chan_strap is also set
	input  wire logic                     wr_ch1,           // software address write, ch1
	input  wire logic                     wr_ch2,           // software address write, ch2
	input  wire bac_addr_t                wr_addr,          // written address
	input  wire logic                     sync_wr,          // attempt to set sync over the bus
	input  wire logic [`BAC_FREQ_W-1:0]   freq_hz_ch1,      // frequency response setting ch1
	input  wire logic [`BAC_FREQ_W-1:0]   freq_hz_ch2,      // frequency response setting ch2
	input  wire logic [`BAC_EXC_W-1:0]    exc_sel_ch1,      // own excitation choice ch1
	input  wire logic [`BAC_EXC_W-1:0]    exc_sel_ch2,      // own excitation choice ch2
	input  wire logic [`BAC_EXC_W-1:0]    ext_exc_sel,      // excitation of an outside master
	output bac_addr_t                     addr_ch1,
	output bac_addr_t                     addr_ch2,
	output logic                          cfg_valid,        // switches sampled, settings frozen
	output bac_sync_e                     sync_mode,
	output bac_role_e                     role_ch1,
	output bac_role_e                     role_ch2,
	output logic                          auto_recog_ch1,   // automatic sensor recognition allowed
	output logic                          auto_recog_ch2,
	output logic [`BAC_EXC_W-1:0]         exc_out_ch1,      // excitation actually used
	output logic [`BAC_EXC_W-1:0]         exc_out_ch2,
	output logic                          wr_ack,           // write stored
	output logic                          wr_fixed,         // stored value was parity-corrected
	output logic                          wr_refused,       // write dropped
	output logic                          sync_wr_refused   // bus sync write dropped
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
		$error("SETTLE_CYCLES must be 1..65535");
	end

	localparam int PIN_W = `BAC_ASW_W + 4;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [PIN_W-1:0] pin_meta;   // first stage, read only by pin_sync
	logic [PIN_W-1:0] pin_sync;   // second stage

	// switches and straps are asynchronous pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {sw_addr_strap, two_chan_strap, sync_sw, addr_sw};
			pin_sync <= pin_meta;
		end
	end

	// ----------------------------------------------------------------
	// power-up sequence
	// ----------------------------------------------------------------
	bac_state_e   state;          // settle or run
	logic [15:0]  settle_cnt;     // cycles waited so far
	logic         two_chan;       // latched strap
	logic         sw_mode;        // latched strap
	logic [`BAC_ASW_W-1:0] sw_val; // latched address switches

	// wait covers bounce and synchroniser fill before the one sample
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= BAC_ST_SETTLE;
			settle_cnt <= 16'h0000;
		end else if (state == BAC_ST_SETTLE) begin
			if (settle_cnt == 16'(SETTLE_CYCLES - 1)) begin
				state <= BAC_ST_RUN;
			end else begin
				settle_cnt <= settle_cnt + 16'h0001;
			end
		end
	end

	logic sample;  // one-cycle sample strobe
	assign sample = (state == BAC_ST_SETTLE) && (settle_cnt == 16'(SETTLE_CYCLES - 1));

	// switch settings held until the next power cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_valid <= 1'b0;
			two_chan  <= 1'b0;
			sw_mode   <= 1'b0;
			sw_val    <= '0;
			sync_mode <= BAC_SYNC_INDEP;
		end else if (sample) begin
			cfg_valid <= 1'b1;
			sw_val    <= pin_sync[`BAC_ASW_W-1:0];
			two_chan  <= pin_sync[`BAC_ASW_W+2];
			sw_mode   <= pin_sync[`BAC_ASW_W+3];
			// no bus path can reach this register
			sync_mode <= bac_sync_e'({pin_sync[`BAC_ASW_W+`BAC_SYNC_S1],
				pin_sync[`BAC_ASW_W+`BAC_SYNC_S2]});
		end
	end

	// ----------------------------------------------------------------
	// address handling
	// ----------------------------------------------------------------
	bac_addr_t fix1_val;
	bac_addr_t fix2_val;
	logic      fix1_ok;
	logic      fix2_ok;
	logic      fix1_cor;
	logic      fix2_cor;

	bac_addr_fix u_fix1 (
		.wr_val    (wr_addr),
		.is_ch2    (1'b0),
		.two_chan  (two_chan),
		.fixed_val (fix1_val),
		.in_range  (fix1_ok),
		.corrected (fix1_cor)
	);

	bac_addr_fix u_fix2 (
		.wr_val    (wr_addr),
		.is_ch2    (1'b1),
		.two_chan  (two_chan),
		.fixed_val (fix2_val),
		.in_range  (fix2_ok),
		.corrected (fix2_cor)
	);

	logic      sw_pair;    // two-channel unit addressed by switches
	logic      wr_any;     // any address write this cycle
	logic      wr_good;    // write will be stored
	bac_addr_t sw_addr1;   // ch1 address from the switches
	logic      sw_pair_now;
	logic [`BAC_ASW_W-1:0] sw_now;

	assign sw_now      = pin_sync[`BAC_ASW_W-1:0];
	assign sw_pair_now = pin_sync[`BAC_ASW_W+2] && pin_sync[`BAC_ASW_W+3];
	assign sw_pair     = two_chan && sw_mode;
	assign wr_any      = wr_ch1 || wr_ch2;
	// ch1 wins when both strobes come together
	assign wr_good     = cfg_valid && !sw_pair && (wr_ch1 ? fix1_ok : fix2_ok);
	// all-off is the factory pair 126/125
	assign sw_addr1    = (sw_now == '0) ? `BAC_ADDR_CH1_RST : bac_addr_t'({sw_now, 1'b0});

	// addresses: switches at sample, software writes afterwards
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ch1 <= `BAC_ADDR_CH1_RST;
			addr_ch2 <= `BAC_ADDR_CH2_RST;
		end else if (sample && sw_pair_now) begin
			addr_ch1 <= sw_addr1;
			addr_ch2 <= bac_addr_t'(sw_addr1 - `BAC_ADDR_STEP);
		end else if (wr_any && wr_good) begin
			if (wr_ch1) begin
				addr_ch1 <= fix1_val;
			end else begin
				addr_ch2 <= fix2_val;
			end
		end
	end

	// write answers, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ack          <= 1'b0;
			wr_fixed        <= 1'b0;
			wr_refused      <= 1'b0;
			sync_wr_refused <= 1'b0;
		end else begin
			wr_ack          <= wr_any && wr_good;
			wr_fixed        <= wr_any && wr_good && (wr_ch1 ? fix1_cor : fix2_cor);
			wr_refused      <= wr_any && !wr_good;
			sync_wr_refused <= sync_wr;
		end
	end

	// ----------------------------------------------------------------
	// sync roles and excitation
	// ----------------------------------------------------------------
	logic      f1_ok;        // ch1 fast enough to sync
	logic      f2_ok;
	bac_role_e next_role1;
	bac_role_e next_role2;

	assign f1_ok = freq_hz_ch1 >= `BAC_SYNC_MIN_HZ;
	assign f2_ok = freq_hz_ch2 >= `BAC_SYNC_MIN_HZ;

	// slow channels fall back to independent rather than sync badly
	always_comb begin
		next_role1 = BAC_ROLE_INDEP;
		next_role2 = BAC_ROLE_INDEP;
		if (cfg_valid) begin
			next_role1 = f1_ok ? bac_chan_role(sync_mode, 1'b0) : BAC_ROLE_INDEP;
			if (two_chan && f2_ok) begin
				next_role2 = bac_chan_role(sync_mode, 1'b1);
			end
		end
	end

	// roles follow frequency settings, which may change at run time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			role_ch1       <= BAC_ROLE_INDEP;
			role_ch2       <= BAC_ROLE_INDEP;
			auto_recog_ch1 <= 1'b1;
			auto_recog_ch2 <= 1'b1;
		end else begin
			role_ch1       <= next_role1;
			role_ch2       <= next_role2;
			auto_recog_ch1 <= next_role1 != BAC_ROLE_SLAVE;
			auto_recog_ch2 <= next_role2 != BAC_ROLE_SLAVE;
		end
	end

	// a ch2 slave in master/slave mode takes exc_sel_ch1 even when ch1 is not master; any other slave follows the outside master
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exc_out_ch1 <= '0;
			exc_out_ch2 <= '0;
		end else begin
			exc_out_ch1 <= (next_role1 == BAC_ROLE_SLAVE) ? ext_exc_sel : exc_sel_ch1;
			if (next_role2 != BAC_ROLE_SLAVE) begin
				exc_out_ch2 <= exc_sel_ch2;
			end else if (sync_mode == BAC_SYNC_M_S) begin
				exc_out_ch2 <= exc_sel_ch1;
			end else begin
				exc_out_ch2 <= ext_exc_sel;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_range;
		cfg_valid |-> addr_ch1 >= `BAC_ADDR_MIN && addr_ch1 <= `BAC_ADDR_MAX
			&& addr_ch2 >= `BAC_ADDR_MIN && addr_ch2 <= `BAC_ADDR_MAX;
	endproperty
	a_range: assert property (p_range) else $error("address out of range");

	property p_pair;
		cfg_valid && sw_pair |-> addr_ch2 == bac_addr_t'(addr_ch1 - `BAC_ADDR_STEP);
	endproperty
	a_pair: assert property (p_pair) else $error("switch pair not adjacent");

	property p_parity;
		cfg_valid && two_chan && $past(cfg_valid) |-> !addr_ch1[0] && addr_ch2[0];
	endproperty
	a_parity: assert property (p_parity) else $error("channel parity broken");

	property p_fix;
		cfg_valid && !sw_pair && two_chan && wr_ch1 && fix1_ok && wr_addr[0]
			|=> addr_ch1 == bac_addr_t'($past(wr_addr) + `BAC_ADDR_STEP) && wr_fixed && wr_ack;
	endproperty
	a_fix: assert property (p_fix) else $error("odd ch1 write not moved up");

	property p_sw_map;
		$rose(cfg_valid) && sw_pair |-> addr_ch1 ==
			((sw_val == '0) ? `BAC_ADDR_CH1_RST : bac_addr_t'({sw_val, 1'b0}));
	endproperty
	a_sw_map: assert property (p_sw_map) else $error("switch address decode wrong");

	property p_role;
		cfg_valid && two_chan && f1_ok && f2_ok && sync_mode == BAC_SYNC_M_S
			|=> role_ch1 == BAC_ROLE_MASTER && role_ch2 == BAC_ROLE_SLAVE;
	endproperty
	a_role: assert property (p_role) else $error("master/slave roles wrong");

	property p_low_freq;
		!f1_ok |=> role_ch1 == BAC_ROLE_INDEP;
	endproperty
	a_low_freq: assert property (p_low_freq) else $error("slow channel synced");

	property p_no_recog;
		(role_ch1 == BAC_ROLE_SLAVE) != auto_recog_ch1 && (role_ch2 == BAC_ROLE_SLAVE) != auto_recog_ch2;
	endproperty
	a_no_recog: assert property (p_no_recog) else $error("slave kept recognition");

	property p_exc;
		cfg_valid && two_chan && f2_ok && sync_mode == BAC_SYNC_M_S |=> exc_out_ch2 == $past(exc_sel_ch1);
	endproperty
	a_exc: assert property (p_exc) else $error("slave not on master frequency");

	// sync_mode can change only at the one sample edge, and no bus path reaches it, so only frozen settings must hold still
	property p_frozen;
		cfg_valid |=> $stable(sync_mode) && cfg_valid;
	endproperty
	a_frozen: assert property (p_frozen) else $error("sync mode changed after sampling");

	property p_settle;
		$rose(cfg_valid) |-> $past(state) == BAC_ST_SETTLE && $past(settle_cnt) == 16'(SETTLE_CYCLES - 1);
	endproperty
	a_settle: assert property (p_settle) else $error("sampled before settle");

	c_sw_pair:  cover property (cfg_valid && sw_pair);
	c_fixed:    cover property (wr_fixed);
	c_both_sl:  cover property (role_ch1 == BAC_ROLE_SLAVE && role_ch2 == BAC_ROLE_SLAVE);
	c_sync_ref: cover property (sync_wr_refused);

endmodule

// [verif/bac_bus_master.sv]
// bus master model that writes channel addresses and tries sync writes
module bac_bus_master
	import bac_pkg::*;
#(
	parameter bac_addr_t OWN_ADDR   = 7'h01,
	parameter int        GAP_CYCLES = 2
)(
	input  wire logic  clk,
	input  wire logic  wr_ack,
	input  wire logic  wr_fixed,
	input  wire logic  wr_refused,
	input  wire logic  sync_wr_refused,
	output logic       wr_ch1,
	output logic       wr_ch2,
	output bac_addr_t  wr_addr,
	output logic       sync_wr
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// idle line state
	// ----------------------------------------------------------------
	// data line idles on the complement of OWN_ADDR until the first write
	initial begin
		wr_ch1 = 1'b0;
		wr_ch2 = 1'b0;
		sync_wr = 1'b0;
		wr_addr = ~OWN_ADDR;
	end

	// one exchange: strobe for one cycle, take the reply at the release edge
	task automatic write_addr(input logic ch2, input bac_addr_t v, output logic [2:0] rsp);
		@(posedge clk);
		#10;
		wr_ch1 = !ch2;
		wr_ch2 = ch2;
		wr_addr = v;
		@(posedge clk);
		#10;
		rsp = {wr_ack, wr_fixed, wr_refused};
		wr_ch1 = 1'b0;
		wr_ch2 = 1'b0;
		wr_addr = ~v;  // released data no longer shows the last value
		repeat (GAP_CYCLES) @(posedge clk);
		#10;
	endtask

	// try to change sync mode over the bus
	task automatic try_sync(output logic rsp);
		@(posedge clk);
		#10;
		sync_wr = 1'b1;
		@(posedge clk);
		#10;
		rsp = sync_wr_refused;
		sync_wr = 1'b0;
		repeat (GAP_CYCLES) @(posedge clk);
		#10;
	endtask
endmodule

// [verif/bac_config_tb.sv]
// self-checking testbench for the bus address and sync configuration block
module bac_config_tb import bac_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [5:0]  addr_sw = 6'h00;
	logic [1:0]  sync_sw = 2'h0;
	logic        two_chan_strap = 1'b1;
	logic        sw_addr_strap = 1'b1;
	logic        wr_ch1, wr_ch2, sync_wr;
	bac_addr_t   wr_addr, addr_ch1, addr_ch2;
	logic [15:0] freq_hz_ch1 = 16'h0064;
	logic [15:0] freq_hz_ch2 = 16'h0064;
	logic [2:0]  exc_sel_ch1 = 3'h1;
	logic [2:0]  exc_sel_ch2 = 3'h2;
	logic [2:0]  ext_exc_sel = 3'h5;
	logic        cfg_valid, auto_recog_ch1, auto_recog_ch2;
	bac_sync_e   sync_mode;
	bac_role_e   role_ch1, role_ch2;
	logic [2:0]  exc_out_ch1, exc_out_ch2;
	logic        wr_ack, wr_fixed, wr_refused, sync_wr_refused;
	logic [2:0]  rsp;
	logic        srsp;
	int          bad_count = 0;
	int          checked = 0;
	logic [5:0]  asw_tab [6] = '{6'h00, 6'h01, 6'h02, 6'h3B, 6'h3E, 6'h3F};
	// {ch2, value, expected address, ack fixed refused}
	// no row leaves both channels on one address
	logic [17:0] wtab [9] = '{{1'b0, 7'h05, 7'h06, 3'h6}, {1'b0, 7'h7D, 7'h7E, 3'h6},
		{1'b0, 7'h7E, 7'h7E, 3'h4}, {1'b1, 7'h0A, 7'h09, 3'h6}, {1'b1, 7'h03, 7'h03, 3'h4},
		{1'b1, 7'h7E, 7'h7D, 3'h6}, {1'b0, 7'h00, 7'h7E, 3'h1}, {1'b1, 7'h7F, 7'h7D, 3'h1},
		{1'b0, 7'h40, 7'h40, 3'h4}};

	// short settle count keeps each power-up to a few cycles
	bac_config #(.SETTLE_CYCLES(4)) bac_config_inst (.clk(clk), .rst_n(rst_n), .addr_sw(addr_sw),
		.sync_sw(sync_sw), .two_chan_strap(two_chan_strap), .sw_addr_strap(sw_addr_strap),
		.wr_ch1(wr_ch1), .wr_ch2(wr_ch2), .wr_addr(wr_addr), .sync_wr(sync_wr),
		.freq_hz_ch1(freq_hz_ch1), .freq_hz_ch2(freq_hz_ch2), .exc_sel_ch1(exc_sel_ch1),
		.exc_sel_ch2(exc_sel_ch2), .ext_exc_sel(ext_exc_sel), .addr_ch1(addr_ch1), .addr_ch2(addr_ch2),
		.cfg_valid(cfg_valid), .sync_mode(sync_mode), .role_ch1(role_ch1), .role_ch2(role_ch2),
		.auto_recog_ch1(auto_recog_ch1), .auto_recog_ch2(auto_recog_ch2), .exc_out_ch1(exc_out_ch1),
		.exc_out_ch2(exc_out_ch2), .wr_ack(wr_ack), .wr_fixed(wr_fixed), .wr_refused(wr_refused),
		.sync_wr_refused(sync_wr_refused));

	// one master and one controller on the line, far below the participant limit
	bac_bus_master bac_bus_master_inst (.clk(clk), .wr_ack(wr_ack), .wr_fixed(wr_fixed),
		.wr_refused(wr_refused), .sync_wr_refused(sync_wr_refused), .wr_ch1(wr_ch1), .wr_ch2(wr_ch2),
		.wr_addr(wr_addr), .sync_wr(sync_wr));

	// ----------------------------------------------------------------
	// clock, compare and close
	// ----------------------------------------------------------------
	always #50 clk = ~clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// reset with given straps and switches, wait for the settings to freeze
	task automatic power_up(input logic two, input logic sw, input logic [5:0] asw, input logic [1:0] mode);
		int n = 0;
		@(posedge clk);
		#10;
		rst_n = 1'b0;
		two_chan_strap = two;
		sw_addr_strap = sw;
		addr_sw = asw;
		sync_sw = {mode[0], mode[1]};  // bit0 is the first switch, code is {s1, s2}
		repeat (6) @(posedge clk);
		#10;
		rst_n = 1'b1;
		chk(8'(addr_ch1), 8'h7E);
		chk(8'(cfg_valid), 8'h00);
		while (cfg_valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			#10;
			n++;
		end
		chk(8'(cfg_valid), 8'h01);
		repeat (2) @(posedge clk);
		#10;
	endtask

	// expected roles, recognition and excitation worked out from the switch code
	task automatic check_roles(input logic [1:0] mode, input logic two);
		logic [1:0] r1;
		logic [1:0] r2;
		r1 = (mode == 2'b00) ? 2'h0 : (mode == 2'b01) ? 2'h1 : 2'h2;
		r2 = (mode == 2'b01 || mode == 2'b11) ? 2'h2 : 2'h0;
		if (freq_hz_ch1 < 16'h0032) r1 = 2'h0;
		if (freq_hz_ch2 < 16'h0032 || !two) r2 = 2'h0;
		chk(8'(sync_mode), 8'(mode));
		chk(8'(role_ch1), 8'(r1));
		chk(8'(role_ch2), 8'(r2));
		chk(8'(auto_recog_ch1), 8'(r1 != 2'h2));
		chk(8'(auto_recog_ch2), 8'(r2 != 2'h2));
		chk(8'(exc_out_ch1), 8'((r1 == 2'h2) ? ext_exc_sel : exc_sel_ch1));
		chk(8'(exc_out_ch2), 8'((r2 != 2'h2) ? exc_sel_ch2 : (mode == 2'b01) ? exc_sel_ch1 : ext_exc_sel));
	endtask

	task automatic wr(input logic ch2, input bac_addr_t v, input bac_addr_t exp_addr, input logic [2:0] exp_rsp);
		bac_bus_master_inst.write_addr(ch2, v, rsp);
		chk(8'(rsp), 8'(exp_rsp));
		chk(8'(ch2 ? addr_ch2 : addr_ch1), 8'(exp_addr));
	endtask

	// ----------------------------------------------------------------
	// watchdog: whole run needs well under 2000 cycles
	// ----------------------------------------------------------------
	initial begin
		#(100 * 5000);
		bad_count++;
		close_out();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		bac_addr_t e1;
		// switch mode: every sync code, boundary switch values
		for (int i = 0; i < 6; i++) begin
			power_up(1'b1, 1'b1, asw_tab[i], i[1:0]);
			e1 = (asw_tab[i] == 6'h00) ? 7'h7E : {asw_tab[i], 1'b0};
			chk(8'(addr_ch1), 8'(e1));
			chk(8'(addr_ch2), 8'(e1 - 7'h01));
			check_roles(i[1:0], 1'b1);
			// switches moved after sampling are ignored
			addr_sw = ~addr_sw;
			sync_sw = ~sync_sw;
			bac_bus_master_inst.try_sync(srsp);
			chk(8'(srsp), 8'h01);
			chk(8'(addr_ch1), 8'(e1));
			check_roles(i[1:0], 1'b1);
			wr(1'b0, 7'h0A, e1, 3'h1);
			$display("switch test %0d done", i);
		end
		// frequency threshold, at 50 Hz and one step below
		power_up(1'b1, 1'b1, 6'h05, 2'b01);
		freq_hz_ch2 = 16'h0031;
		repeat (2) @(posedge clk);
		#10;
		check_roles(2'b01, 1'b1);
		freq_hz_ch2 = 16'h0032;
		repeat (2) @(posedge clk);
		#10;
		check_roles(2'b01, 1'b1);
		power_up(1'b1, 1'b1, 6'h05, 2'b11);
		freq_hz_ch1 = 16'h0031;
		repeat (2) @(posedge clk);
		#10;
		check_roles(2'b11, 1'b1);
		freq_hz_ch1 = 16'h0064;
		$display("frequency test done");
		// software addresses on a two-channel unit
		power_up(1'b1, 1'b0, 6'h05, 2'b00);
		chk(8'(addr_ch1), 8'h7E);
		chk(8'(addr_ch2), 8'h7D);
		foreach (wtab[k]) begin
			wr(wtab[k][17], wtab[k][16:10], wtab[k][9:3], wtab[k][2:0]);
		end
		$display("software address test done");
		// single-channel unit: no parity rules, ch2 never takes a sync role
		power_up(1'b0, 1'b1, 6'h05, 2'b01);
		chk(8'(addr_ch1), 8'h7E);
		check_roles(2'b01, 1'b0);
		wr(1'b0, 7'h05, 7'h05, 3'h4);
		wr(1'b1, 7'h0A, 7'h0A, 3'h4);
		$display("single channel test done");
		close_out();
	end
endmodule
